// [rtl/sync_serial_pkg.sv]
// Shared constants for the clocked serial master port and its slave partner
package sync_serial_pkg;
   localparam int          DATA_W        = 9;
   localparam int          CHAR8_BITS    = 8;
   localparam int          CHAR9_BITS    = 9;
   localparam logic [15:0] BAUD_RESET    = 16'h0004;
   localparam int          LINK_CLK_NS   = 160;
   localparam int          SYS_CLK_NS    = 20;
   localparam int          SYNC_STAGES   = 2;
   localparam int          FIFO_DEPTH    = 2;
   localparam logic [3:0]  BIT_CNT_RESET = 4'h0;
endpackage

// [rtl/sync_serial_if.sv]
// Two-wire link between the master port and a slave device
`timescale 1ns/1ns
interface sync_serial_if;
   logic clk_m_o;
   logic clk_m_oe;
   logic clk_s_o;
   logic clk_s_oe;
   logic dat_m_o;
   logic dat_m_oe;
   logic dat_s_o;
   logic dat_s_oe;
   wire  shift_clock_pin;
   wire  serial_data_pin;

   // Wire levels resolved from the enables; undriven lines idle low
   assign shift_clock_pin = clk_m_oe ? clk_m_o : (clk_s_oe ? clk_s_o : 1'b0);
   assign serial_data_pin = dat_m_oe ? dat_m_o : (dat_s_oe ? dat_s_o : 1'b0);

   modport master (output clk_m_o, clk_m_oe, dat_m_o, dat_m_oe,
                   input shift_clock_pin, serial_data_pin);
   modport slave  (output clk_s_o, clk_s_oe, dat_s_o, dat_s_oe,
                   input shift_clock_pin, serial_data_pin);
endinterface

// [rtl/sync_serial_slave.sv]
// Slave end: shifts characters in and out on the master's clock
`timescale 1ns/1ns
module sync_serial_slave
(
   input  wire logic                              clk_sys_i,
   input  wire logic                              rst_i,
   input  wire logic                              clk_en_i,
   input  wire logic                              polarity_i,
   input  wire logic                              nine_bit_i,
   input  wire logic                              transmit_i,
   input  wire logic [sync_serial_pkg::DATA_W-1:0] tx_data_i,
   output logic      [sync_serial_pkg::DATA_W-1:0] rx_data_o,
   output logic                                   rx_valid_o,
   sync_serial_if.slave                           link
);
   import sync_serial_pkg::*;

   logic [1:0]        ck_sync_r;
   logic [1:0]        dt_sync_r;
   logic              ck_prev_r;
   logic [DATA_W-1:0] sh_r;
   logic [3:0]        cnt_r;
   logic              dat_r;
   logic              ck_now;
   logic              lead;
   logic              trail;
   logic [3:0]        nbits;

   // Edges from the raw level, so a polarity change is no edge
   assign ck_now = ck_sync_r[1];
   assign lead   = (ck_now ^ polarity_i) & (ck_now ^ ck_prev_r);
   assign trail  = ~(ck_now ^ polarity_i) & (ck_now ^ ck_prev_r);
   assign nbits  = nine_bit_i ? 4'(CHAR9_BITS) : 4'(CHAR8_BITS);

   // Pin synchronisers
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ck_sync_r <= 2'h0;
         dt_sync_r <= 2'h0;
         ck_prev_r <= 1'b0;
      end
      else if (clk_en_i)
      begin
         ck_sync_r <= {ck_sync_r[0], link.shift_clock_pin};
         dt_sync_r <= {dt_sync_r[0], link.serial_data_pin};
         ck_prev_r <= ck_now;
      end
   end

   // Shift: drive on leading edge, sample on trailing, LSB first
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sh_r       <= '0;
         cnt_r      <= BIT_CNT_RESET;
         dat_r      <= 1'b0;
         rx_data_o  <= '0;
         rx_valid_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         rx_valid_o <= 1'b0;
         if (lead && transmit_i)
         begin
            dat_r <= (cnt_r == BIT_CNT_RESET) ? tx_data_i[0] : sh_r[0];
            if (cnt_r == BIT_CNT_RESET)
               sh_r <= tx_data_i >> 1;
            else
               sh_r <= sh_r >> 1;
         end
         if (trail)
         begin
            if (!transmit_i)
               sh_r <= {dt_sync_r[1], sh_r[DATA_W-1:1]};
            if (cnt_r == nbits - 4'h1)
            begin
               cnt_r <= BIT_CNT_RESET;
               if (!transmit_i)
               begin
                  rx_valid_o <= 1'b1;
                  rx_data_o  <= nine_bit_i ?
                     {dt_sync_r[1], sh_r[DATA_W-1:1]} :
                     {1'b0, dt_sync_r[1], sh_r[DATA_W-1:2]};
               end
            end
            else
               cnt_r <= cnt_r + 4'h1;
         end
      end
   end

   // Slave never drives the clock; drives data only when transmitting
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         link.clk_s_o  <= 1'b0;
         link.clk_s_oe <= 1'b0;
         link.dat_s_o  <= 1'b0;
         link.dat_s_oe <= 1'b0;
      end
      else if (clk_en_i)
      begin
         link.dat_s_o  <= dat_r;
         link.dat_s_oe <= transmit_i;
      end
   end
endmodule // sync_serial_slave

// [rtl/sync_serial_master.sv]
// Master end: clocked serial master port with AXI4-Lite registers
//
// Operation
// RULE_01: one clock line, one data line, half-duplex
// RULE_02: no start or stop bits
// RULE_03: master only when mode, source, enable set
// RULE_04: both receive enables clear means transmit
// RULE_05: master drives clock pin when configured; code drives it only while a receive enable or transmit_enable_r is also set
// RULE_06: one clock cycle per data bit
// RULE_07: polarity sets idle level and data edge
// RULE_08: transmit drives data and clock pins
// RULE_09: holding register write starts or queues transmission
// RULE_10: data changes on leading clock edge
// RULE_11: transmit shift register not software visible
// RULE_12: receive releases the data pin
// RULE_13: single receive: one character, then self-clear
// RULE_14: continuous receive runs; clearing aborts character
// RULE_15: both set: single clears, continuous continues
// RULE_16: sample data on trailing clock edge
// RULE_17: two-entry FIFO, pending flag while unread
// RULE_18: third character sets overrun, blocks reception
// RULE_19: overrun clear depends on receive mode
// RULE_20: ninth bit read separately, before low byte
// RULE_21: load ninth transmit bit before low byte
// RULE_22: software configures, then sets a receive enable
// RULE_23: clock period from baud divisor, only shifting
// RULE_24: least significant bit first, ninth last
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module sync_serial_master
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        clk_en_i,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   sync_serial_if.master    link
);
   import sync_serial_pkg::*;

   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] STAT_OFS = 5'h04;
   localparam logic [4:0] TXD_OFS  = 5'h08;
   localparam logic [4:0] RXD_OFS  = 5'h0c;
   localparam logic [4:0] BAUD_OFS = 5'h10;

   typedef enum logic [1:0] {IDLE = 2'b00, LEAD = 2'b01,
                             TRAIL = 2'b11} sh_state_e;

   // Control bits
   logic sync_mode_r, clock_source_master_select_r, serial_port_enable_r;
   logic single_receive_enable_r, continuous_receive_enable_r;
   logic shift_clock_polarity_r, transmit_enable_r;
   logic transmit_ninth_bit_select_r, transmit_ninth_bit_value_r;
   logic receive_ninth_bit_select_r;
   logic [15:0] baud_r;
   // Transmit path; shift register has no address
   logic [DATA_W-1:0] thr_r;                           // [RULE_11]
   logic              thr_full_r;
   logic [DATA_W-1:0] tsr_r;
   logic [DATA_W-1:0] rsr_r;
   logic [DATA_W-1:0] fifo_r [FIFO_DEPTH];
   logic [1:0]        fifo_cnt_r;
   logic              receive_overrun_flag_r;
   logic              ovf_single_r;
   sh_state_e         st_r;
   logic [15:0]       div_r;
   logic [3:0]        bit_r;
   logic              rx_dir_r;
   logic [1:0]        dt_sync_r;
   logic              ck_lvl_r;
   // Bus
   logic        aw_h_r, w_h_r;
   logic [4:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic        master_on, rx_dir, tick, last_bit, wr_go, rd_go;
   logic        rd_rxd, char_done;
   logic [3:0]  nbits;

   assign master_on = sync_mode_r & clock_source_master_select_r &
                      serial_port_enable_r;                    // [RULE_03]
   assign rx_dir    = single_receive_enable_r |
                      continuous_receive_enable_r;             // [RULE_04]
   assign nbits     = (rx_dir ? receive_ninth_bit_select_r :
                       transmit_ninth_bit_select_r) ?
                      4'(CHAR9_BITS) : 4'(CHAR8_BITS);        // [RULE_02]
   assign tick      = (div_r == 16'h0000);                    // [RULE_23]
   assign last_bit  = (bit_r == nbits - 4'h1);                // [RULE_06]
   assign wr_go     = aw_h_r & w_h_r & ~s_axi_bvalid;
   assign rd_go     = s_axi_arvalid & s_axi_arready;
   assign rd_rxd    = rd_go & (s_axi_araddr == RXD_OFS);
   assign char_done = (st_r == TRAIL) & tick & last_bit;

   // Write address and data captured independently
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         aw_h_r <= 1'b0;
         w_h_r  <= 1'b0;
         awaddr_r <= 5'h00;
         wdata_r  <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_h_r   <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_h_r   <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (wr_go)
         begin
            aw_h_r <= 1'b0;
            w_h_r  <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   assign s_axi_awready = ~aw_h_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_h_r & ~s_axi_bvalid;
   assign s_axi_bresp   = 2'b00;

   // Read channel; unmapped reads return zero with OKAY
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
      end
      else if (clk_en_i)
      begin
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
               CTRL_OFS: s_axi_rdata <= {22'h0, receive_ninth_bit_select_r,
                  transmit_ninth_bit_value_r, transmit_ninth_bit_select_r,
                  transmit_enable_r, shift_clock_polarity_r,
                  continuous_receive_enable_r, single_receive_enable_r,
                  serial_port_enable_r, clock_source_master_select_r,
                  sync_mode_r};
               // Ninth bit here, read before the data word [RULE_20]
               STAT_OFS: s_axi_rdata <= {26'h0, st_r != IDLE, thr_full_r,
                  fifo_r[0][8], receive_overrun_flag_r, 1'b0,
                  fifo_cnt_r != 2'h0};                         // [RULE_17]
               RXD_OFS:  s_axi_rdata <= {24'h0, fifo_r[0][7:0]};
               BAUD_OFS: s_axi_rdata <= {16'h0, baud_r};
               default:  s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = ~s_axi_rvalid;
   assign s_axi_rresp   = 2'b00;

   // Control register; hardware self-clear of single receive wins
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         {sync_mode_r, clock_source_master_select_r} <= 2'b00;
         serial_port_enable_r        <= 1'b0;
         single_receive_enable_r     <= 1'b0;
         continuous_receive_enable_r <= 1'b0;
         shift_clock_polarity_r      <= 1'b0;
         transmit_enable_r           <= 1'b0;
         transmit_ninth_bit_select_r <= 1'b0;
         transmit_ninth_bit_value_r  <= 1'b0;
         receive_ninth_bit_select_r  <= 1'b0;
         baud_r <= BAUD_RESET;
      end
      else if (clk_en_i)
      begin
         if (wr_go && awaddr_r == CTRL_OFS && s_axi_wstrb[0])
         begin
            {shift_clock_polarity_r, continuous_receive_enable_r,
             single_receive_enable_r, serial_port_enable_r,
             clock_source_master_select_r, sync_mode_r} <= wdata_r[5:0];
         end
         if (wr_go && awaddr_r == CTRL_OFS && s_axi_wstrb[1])
         begin
            {receive_ninth_bit_select_r, transmit_ninth_bit_value_r,
             transmit_ninth_bit_select_r} <= wdata_r[9:7];
            transmit_enable_r <= wdata_r[6];
         end
         else if (wr_go && awaddr_r == CTRL_OFS && s_axi_wstrb[0])
            transmit_enable_r <= wdata_r[6];
         if (wr_go && awaddr_r == BAUD_OFS)
            baud_r <= wdata_r[15:0];
         if (char_done && rx_dir_r)
            single_receive_enable_r <= 1'b0;          // [RULE_13] [RULE_15]
      end
   end

   // Data pin synchroniser
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
         dt_sync_r <= 2'h0;
      else if (clk_en_i)
         dt_sync_r <= {dt_sync_r[0], link.serial_data_pin};
   end

   // Holding register: loaded by software, drained into the shifter
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         thr_r      <= '0;
         thr_full_r <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (!serial_port_enable_r)
            thr_full_r <= 1'b0;
         else if (wr_go && awaddr_r == TXD_OFS)
         begin
            // Ninth bit must already be loaded [RULE_21]
            thr_r      <= {transmit_ninth_bit_value_r, wdata_r[7:0]};
            thr_full_r <= 1'b1;                                // [RULE_09]
         end
         else if (st_r == IDLE && thr_full_r && master_on && !rx_dir &&
                  transmit_enable_r)
            thr_full_r <= 1'b0;
      end
   end

   // Shift engine: half-bit timer from divisor, LEAD then TRAIL per bit
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_r     <= IDLE;
         div_r    <= 16'h0000;
         bit_r    <= BIT_CNT_RESET;
         tsr_r    <= '0;
         rsr_r    <= '0;
         rx_dir_r <= 1'b0;
         ck_lvl_r <= 1'b0;
      end
      else if (clk_en_i)
      begin
         div_r <= tick ? baud_r : div_r - 16'h0001;            // [RULE_23]
         case (st_r)
            IDLE:
            begin
               ck_lvl_r <= 1'b0;
               bit_r    <= BIT_CNT_RESET;
               div_r    <= baud_r;
               if (master_on && rx_dir && !receive_overrun_flag_r)
               begin
                  rx_dir_r <= 1'b1;
                  st_r     <= LEAD;
               end
               else if (master_on && !rx_dir && transmit_enable_r &&
                        thr_full_r)
               begin
                  tsr_r    <= thr_r;                           // [RULE_09]
                  rx_dir_r <= 1'b0;
                  st_r     <= LEAD;
               end
            end
            LEAD:
               if (tick)
               begin
                  ck_lvl_r <= 1'b1;                            // [RULE_10]
                  if (!rx_dir_r && bit_r != BIT_CNT_RESET)
                     tsr_r <= tsr_r >> 1;                      // [RULE_24]
                  st_r     <= TRAIL;
               end
            TRAIL:
               if (tick)
               begin
                  ck_lvl_r <= 1'b0;
                  if (rx_dir_r)                                // [RULE_16]
                     rsr_r <= {dt_sync_r[1], rsr_r[DATA_W-1:1]};
                  bit_r <= bit_r + 4'h1;
                  st_r  <= last_bit ? IDLE : LEAD;             // [RULE_06]
               end
            default:
               st_r <= IDLE;
         endcase
         // Abort: partial character discarded, clock stops at once
         if (!master_on || (rx_dir_r && st_r != IDLE && !rx_dir))
         begin
            st_r     <= IDLE;                                  // [RULE_14]
            ck_lvl_r <= 1'b0;
         end
      end
   end

   // Receive FIFO and overrun
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fifo_r[0]  <= '0;
         fifo_r[1]  <= '0;
         fifo_cnt_r <= 2'h0;
         receive_overrun_flag_r <= 1'b0;
         ovf_single_r <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (!serial_port_enable_r)
         begin
            fifo_cnt_r <= 2'h0;                                // [RULE_19]
            receive_overrun_flag_r <= 1'b0;
         end
         else
         begin
            if (rd_rxd && fifo_cnt_r != 2'h0)
            begin
               fifo_r[0] <= fifo_r[1];
               fifo_cnt_r <= fifo_cnt_r - 2'h1;
            end
            if (char_done && rx_dir_r)
            begin
               if (fifo_cnt_r == 2'(FIFO_DEPTH) && !rd_rxd)
               begin
                  receive_overrun_flag_r <= 1'b1;              // [RULE_18]
                  ovf_single_r <= ~continuous_receive_enable_r;
               end
               else
               begin
                  // Align 8-bit characters to the low bits
                  if (fifo_cnt_r == 2'h0 || (fifo_cnt_r == 2'h1 && rd_rxd))
                     fifo_r[0] <= receive_ninth_bit_select_r ?
                        {dt_sync_r[1], rsr_r[DATA_W-1:1]} :
                        {1'b0, dt_sync_r[1], rsr_r[DATA_W-1:2]};
                  else
                     fifo_r[1] <= receive_ninth_bit_select_r ?
                        {dt_sync_r[1], rsr_r[DATA_W-1:1]} :
                        {1'b0, dt_sync_r[1], rsr_r[DATA_W-1:2]};
                  fifo_cnt_r <= fifo_cnt_r + 2'h1 -
                                2'(rd_rxd && fifo_cnt_r != 2'h0);
               end                                             // [RULE_17]
            end
            else if (receive_overrun_flag_r &&
                     ((ovf_single_r && rd_rxd) ||
                      (!ovf_single_r && !continuous_receive_enable_r)))
               receive_overrun_flag_r <= 1'b0;                 // [RULE_19]
         end
      end
   end

   // Pin drivers, all registered; polarity folds into idle level
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         link.clk_m_o  <= 1'b0;
         link.clk_m_oe <= 1'b0;
         link.dat_m_o  <= 1'b0;
         link.dat_m_oe <= 1'b0;
      end
      else if (clk_en_i)
      begin
         link.clk_m_o  <= ck_lvl_r ^ shift_clock_polarity_r;   // [RULE_07]
         link.clk_m_oe <= master_on &&
                          (rx_dir || transmit_enable_r);       // [RULE_05]
         link.dat_m_o  <= tsr_r[0];                            // [RULE_08]
         link.dat_m_oe <= master_on && !rx_dir &&
                          transmit_enable_r;            // [RULE_01] [RULE_12]
      end
   end
endmodule // sync_serial_master

// [bench/sync_serial_sva.sv]
// Link checker for the master and slave ends of the clocked serial port
`timescale 1ns/1ns
module sync_serial_sva
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clk_m_o,
   input wire logic clk_m_oe,
   input wire logic clk_s_o,
   input wire logic clk_s_oe,
   input wire logic dat_m_o,
   input wire logic dat_m_oe,
   input wire logic dat_s_o,
   input wire logic dat_s_oe,
   input wire logic shift_clock_pin,
   input wire logic serial_data_pin
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // One toggle of the master's shift clock
   sequence s_clk_edge;
      $changed(clk_m_o);
   endsequence

   // Drivers on the two wires
   property p_no_data_clash;
      !(dat_m_oe && dat_s_oe);
   endproperty
   property p_slave_no_clk;
      !clk_s_oe;
   endproperty
   property p_data_needs_clk;
      dat_m_oe |-> clk_m_oe;
   endproperty
   property p_clk_driven;
      s_clk_edge |-> clk_m_oe || $past(clk_m_oe);
   endproperty
   // A half period is at least one divisor step plus one, never one cycle
   property p_clk_half;
      s_clk_edge |=> $stable(clk_m_o);
   endproperty
   property p_data_hold;
      $changed(dat_m_o) && dat_m_oe |=> !dat_m_oe || $stable(dat_m_o);
   endproperty
   property p_rx_release;
      dat_s_oe |-> serial_data_pin == dat_s_o;
   endproperty
   property p_clk_pin;
      clk_m_oe |-> shift_clock_pin == clk_m_o;
   endproperty

   a_no_data_clash: assert property (p_no_data_clash)
      else $error("both ends drive the data line");
   a_slave_no_clk: assert property (p_slave_no_clk)
      else $error("slave drives the clock line");
   a_data_needs_clk: assert property (p_data_needs_clk)
      else $error("data driven without clock driver");
   a_clk_driven: assert property (p_clk_driven)
      else $error("clock toggles while undriven");
   a_clk_half: assert property (p_clk_half)
      else $error("clock half period of one cycle");
   a_data_hold: assert property (p_data_hold)
      else $error("data bit held for one cycle only");
   a_rx_release: assert property (p_rx_release)
      else $error("master keeps data line while slave sends");
   a_clk_pin: assert property (p_clk_pin)
      else $error("clock pin differs from master clock");
endmodule // sync_serial_sva

// [bench/sync_serial_master_port_tb_top.sv]
// Bench: master and slave ends joined, driven over AXI4-Lite
`timescale 1ns/1ns
module sync_serial_master_port_tb_top;
   import sync_serial_pkg::*;
   logic              clk_sys_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [4:0]        awaddr = 5'h00, araddr = 5'h00;
   logic [31:0]       wdata = 32'h0, rdata, v;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid;
   logic              pol = 1'b0, nine = 1'b0, sl_tx = 1'b0, sl_rxv;
   logic [DATA_W-1:0] sl_txd = 9'h000, sl_rxd;
   int                error_cnt = 0, tests_run = 0, edges = 0, e;

   sync_serial_if link();
   sync_serial_master sync_serial_master_inst (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .clk_en_i(1'b1), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(link));
   sync_serial_slave sync_serial_slave_inst (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .clk_en_i(1'b1), .polarity_i(pol),
      .nine_bit_i(nine), .transmit_i(sl_tx), .tx_data_i(sl_txd),
      .rx_data_o(sl_rxd), .rx_valid_o(sl_rxv), .link(link));
   sync_serial_sva sync_serial_sva_inst (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .clk_m_o(link.clk_m_o), .clk_m_oe(link.clk_m_oe),
      .clk_s_o(link.clk_s_o), .clk_s_oe(link.clk_s_oe),
      .dat_m_o(link.dat_m_o), .dat_m_oe(link.dat_m_oe),
      .dat_s_o(link.dat_s_o), .dat_s_oe(link.dat_s_oe),
      .shift_clock_pin(link.shift_clock_pin),
      .serial_data_pin(link.serial_data_pin));

   // 50 MHz system clock
   always #10 clk_sys_i = ~clk_sys_i;
   // Count every level change seen on the shared clock wire
   always @(link.shift_clock_pin)
      edges++;

   task end_sim;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // A used-up wait bound counts as a mismatch and ends the run
   task tmo(input int n);
      if (n >= 2000)
      begin
         chk(32'h0, 32'h1, "wait bound used up");
         end_sim;
      end
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 2000; n++)
      begin
         @(posedge clk_sys_i);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      tmo(n);
   endtask
   task rd(input logic [4:0] a, output logic [31:0] d);
      int n;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 2000; n++)
      begin
         @(posedge clk_sys_i);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      d = rdata;
      rready <= 1'b0;
      tmo(n);
   endtask
   // Wait for the slave to flag one character, then compare it
   task srx(input logic [8:0] x);
      int n;
      for (n = 0; n < 2000; n++)
      begin
         @(posedge clk_sys_i);
         if (sl_rxv === 1'b1)
            break;
      end
      tmo(n);
      chk({23'h0, sl_rxd}, {23'h0, x}, "slave character");
   endtask
   // Poll one status bit until set
   task pollst(input int b);
      int n;
      for (n = 0; n < 2000; n++)
      begin
         rd(5'h04, v);
         if (v[b] === 1'b1)
            break;
      end
      tmo(n);
   endtask

   // Two characters back to back, idle low
   task t_tx8;
      wr(5'h00, 32'h047);
      rd(5'h04, v);
      edges = 0;
      wr(5'h08, 32'h0a5);
      wr(5'h08, 32'h03c);
      srx(9'h0a5);
      srx(9'h03c);
      chk(edges, 32, "clock edges");
      chk(link.shift_clock_pin, 0, "idle low");
   endtask
   // Nine-bit character with the clock idling high
   task t_tx9p;
      nine <= 1'b1;
      wr(5'h00, 32'h1e7);
      rd(5'h04, v);
      pol <= 1'b1;
      edges = 0;
      wr(5'h08, 32'h05a);
      srx(9'h15a);
      chk(edges, 18, "clock edges");
      chk(link.shift_clock_pin, 1, "idle high");
   endtask
   // Single receive: one character, then the enable drops
   task t_rx1;
      nine <= 1'b0;
      sl_txd <= 9'h03c;
      wr(5'h00, 32'h007);
      rd(5'h04, v);
      pol <= 1'b0;
      sl_tx <= 1'b1;
      wr(5'h10, 32'h8);
      edges = 0;
      wr(5'h00, 32'h00f);
      pollst(0);
      chk(edges, 16, "clock edges");
      rd(5'h00, v);
      chk(v[3], 0, "single enable");
      rd(5'h0c, v);
      chk(v, 32'h03c, "received");
      rd(5'h04, v);
      chk(v[0], 0, "pending");
   endtask
   // Continuous receive into a full FIFO, then clear the enable
   task t_ovr;
      wr(5'h00, 32'h017);
      pollst(2);
      rd(5'h0c, v);
      chk(v, 32'h03c, "first entry");
      rd(5'h0c, v);
      chk(v, 32'h03c, "second entry");
      rd(5'h04, v);
      chk({v[2], v[0]}, 2'b10, "overrun held");
      wr(5'h00, 32'h007);
      e = edges;
      rd(5'h04, v);
      chk(v[2], 0, "overrun cleared");
      chk(edges, e, "clock stopped");
   endtask
   // Nine-bit reception, top bit in status
   task t_rx9;
      nine <= 1'b1;
      sl_txd <= 9'h1c3;
      wr(5'h00, 32'h20f);
      pollst(0);
      chk(v[3], 1, "ninth bit");
      rd(5'h0c, v);
      chk(v, 32'h0c3, "low byte");
   endtask
   // Disabled port ignores a character; unmapped place reads zero
   task t_off;
      sl_tx <= 1'b0;
      wr(5'h00, 32'h000);
      edges = 0;
      wr(5'h08, 32'h011);
      rd(5'h04, v);
      chk(edges, 0, "no clock");
      chk(v[5], 0, "not busy");
      rd(5'h14, v);
      chk(v, 32'h0, "unmapped");
   endtask

   initial
   begin
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_tx8;
      t_tx9p;
      t_rx1;
      t_ovr;
      t_rx9;
      t_off;
      end_sim;
   end
endmodule // sync_serial_master_port_tb_top
